// *** sector_lock_params.svh ***
// constants for the security sector lock and unique identifier read logic
`ifndef SECTOR_LOCK_PARAMS_SVH
`define SECTOR_LOCK_PARAMS_SVH

// instruction codes and address decode
`define OPC_LOCK_SECTOR 8'h82
`define OPC_READ_LOCK 8'h83
`define LOCK_SELECT 2'h2
`define LOCK_SEL_HI 10
`define LOCK_SEL_LO 9
`define UID_SEL_BIT 9

// bit positions inside the data and status bytes
`define LOCK_DATA_BIT 1
`define LOCK_STATUS_BIT 1

// rising edge counts inside a frame (value of the counter before the edge)
`define ADDR_LAST_CNT 6'h17
`define DATA_LAST_CNT 6'h1f
`define CNT_OVER 6'h20

// identifier size and default value (value is arbitrary)
`define UID_BYTES 16
`define UID_DEFAULT 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0

// reset values
`define OUT_IDX_RST 3'h7

// self-timed write
`define REF_CLK_MHZ 250
`define WRITE_TIME_MS 5
`define WRITE_CYCLES (`WRITE_TIME_MS * 1000 * `REF_CLK_MHZ)

`endif

// *** sector_lock_pkg.sv ***
// types for the security sector lock and unique identifier read logic
package sector_lock_pkg;

	// what the current frame turned out to be, decided after the address
	typedef enum logic [4:0] {
		MODE_IDLE   = 5'h01,
		MODE_LOCK   = 5'h02,
		MODE_STATUS = 5'h04,
		MODE_UID    = 5'h08,
		MODE_OTHER  = 5'h10
	} link_mode_e;

	// status bits held by the rest of the device
	typedef struct packed {
		logic block_protect_hi;
		logic block_protect_lo;
		logic write_enable_latch;
	} protect_s;

	// results of the lock write handed back to the device
	typedef struct packed {
		logic write_in_progress;
		logic wel_clear;
		logic sector_locked;
		logic lock_nv_commit;
	} write_status_s;

endpackage

// *** byte_buffer.sv ***
// two-entry valid/ready buffer between the byte source and the serializer
`timescale 1ns/10ps
module byte_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	// full and empty come straight from the occupancy count
	assign in_ready = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage, no reset needed since count guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// pointers wrap at the depth
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// *** sector_lock_uid.sv ***
// lock instruction, lock status read and unique identifier read of the serial eeprom
`timescale 1ns/10ps
`include "sector_lock_params.svh"
module sector_lock_uid
	import sector_lock_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
	parameter logic [127:0] UID_VALUE = `UID_DEFAULT
) (
	// system clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// serial link
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	// device status and nonvolatile lock cell
	input wire protect_s protect,
	input wire logic lock_nv_state,
	output write_status_s write_status
);
	localparam int TW = $clog2(WRITE_CYCLES + 1);

	// reset synchroniser and the copy the rest of the design uses
	logic rst_meta_reg;
	logic rst_n_reg;
	logic link_rst_n;
	// link side state
	logic [5:0] bit_cnt_reg;
	logic [22:0] shift_reg;
	link_mode_e mode_reg;
	logic [3:0] ptr_reg;
	logic armed_reg;
	logic lock_meta_reg;
	logic lock_sync_reg;
	logic [2:0] out_idx_reg;
	logic shown_reg;
	logic serial_out_reg;
	logic serial_out_en_reg;
	// byte path
	logic [23:0] word;
	logic addr_done;
	logic reading;
	logic read_now;
	logic [3:0] ptr_now;
	logic push_valid;
	logic push_ready;
	logic [7:0] push_data;
	logic head_valid;
	logic head_ready;
	logic [7:0] head_data;
	logic [2:0] out_idx_next;
	// system side state
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic armed_meta_reg;
	logic armed_sync_reg;
	logic init_done_reg;
	logic lock_reg;
	logic wip_reg;
	logic [TW-1:0] timer_reg;
	logic wel_clear_reg;
	logic commit_reg;
	logic arm_fresh_reg;
	logic accept;

	// status byte carries only the lock flag
	function automatic logic [7:0] status_byte(input logic locked);
		logic [7:0] b;
		b = 8'h00;
		b[`LOCK_STATUS_BIT] = locked;
		return b;
	endfunction

	// identifier byte 0 is the most significant byte of the value
	function automatic logic [7:0] uid_byte(input logic [3:0] idx);
		logic [7:0] b;
		b = UID_VALUE[127 - 8 * int'(idx) -: 8];
		return b;
	endfunction

	// asserted asynchronously, released through two flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// the link logic is cleared whenever chip select is high
	assign link_rst_n = rst_n_reg && !cs_n;

	// rising edge capture of the serial stream, counter saturates past a lock frame
	always_ff @(posedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_reg <= 6'h00;
			shift_reg <= '0;
		end else begin
			shift_reg <= {shift_reg[21:0], serial_in};
			if (bit_cnt_reg != `CNT_OVER) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
		end
	end

	// opcode and address including the bit arriving at this edge
	assign word = {shift_reg, serial_in};
	assign addr_done = (bit_cnt_reg == `ADDR_LAST_CNT);

	// frame decode once the sixteenth address bit is in
	always_ff @(posedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			mode_reg <= MODE_IDLE;
		end else if (addr_done) begin
			if (word[23:16] == `OPC_LOCK_SECTOR && word[`LOCK_SEL_HI:`LOCK_SEL_LO] == `LOCK_SELECT) begin
				mode_reg <= MODE_LOCK;
			end else if (word[23:16] == `OPC_READ_LOCK && word[`LOCK_SEL_HI:`LOCK_SEL_LO] == `LOCK_SELECT) begin
				mode_reg <= MODE_STATUS;
			end else if (word[23:16] == `OPC_READ_LOCK && word[`UID_SEL_BIT]) begin
				mode_reg <= MODE_UID;
			end else begin
				mode_reg <= MODE_OTHER;
			end
		end
	end

	// the arm flag must outlive chip select so it is not on the frame reset;
	// any edge after the eighth data bit withdraws it
	always_ff @(posedge spi_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			armed_reg <= 1'b0;
		end else if (bit_cnt_reg == `DATA_LAST_CNT) begin
			armed_reg <= (mode_reg == MODE_LOCK) && shift_reg[`LOCK_DATA_BIT - 1];
		end else begin
			armed_reg <= 1'b0;
		end
	end

	// lock flag brought into the link domain
	always_ff @(posedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			lock_meta_reg <= lock_reg;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// the first byte is pushed on the very edge that completes the address
	assign reading = (mode_reg == MODE_STATUS) || (mode_reg == MODE_UID);
	assign read_now = (word[23:16] == `OPC_READ_LOCK) &&
		((word[`LOCK_SEL_HI:`LOCK_SEL_LO] == `LOCK_SELECT) || word[`UID_SEL_BIT]);
	assign ptr_now = addr_done ? word[3:0] : ptr_reg;
	assign push_valid = addr_done ? read_now : reading;
	always_comb begin
		push_data = uid_byte(ptr_now);
		if (addr_done ? (word[`LOCK_SEL_HI:`LOCK_SEL_LO] == `LOCK_SELECT) : (mode_reg == MODE_STATUS)) begin
			push_data = status_byte(lock_sync_reg);
		end
	end

	// identifier pointer advances per pushed byte and wraps at sixteen
	always_ff @(posedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ptr_reg <= 4'h0;
		end else if (push_valid && push_ready) begin
			ptr_reg <= ptr_now + 4'h1;
		end
	end

	// two bytes in flight let the source run a byte ahead of the serializer
	byte_buffer #(
		.WIDTH(8),
		.DEPTH(2)
	) u_buffer (
		.clk(spi_clk),
		.rst_n(link_rst_n),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(head_valid),
		.out_ready(head_ready),
		.out_data(head_data)
	);

	// head is released at the rising edge that samples its last bit
	assign head_ready = shown_reg && (out_idx_reg == `OUT_IDX_RST);
	assign out_idx_next = out_idx_reg + 3'h1;

	// falling edge serializer, msb first
	always_ff @(negedge spi_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_idx_reg <= `OUT_IDX_RST;
			shown_reg <= 1'b0;
			serial_out_reg <= 1'b0;
			serial_out_en_reg <= 1'b0;
		end else if (reading && head_valid) begin
			out_idx_reg <= out_idx_next;
			serial_out_reg <= head_data[3'h7 - out_idx_next];
			shown_reg <= 1'b1;
			serial_out_en_reg <= 1'b1;
		end
	end

	assign serial_out = serial_out_reg;
	assign serial_out_en = serial_out_en_reg;

	// chip select and arm flag brought into the system domain
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			armed_meta_reg <= 1'b0;
			armed_sync_reg <= 1'b0;
		end else begin
			cs_meta_reg <= cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
			armed_meta_reg <= armed_reg;
			armed_sync_reg <= armed_meta_reg;
		end
	end

	// a frame with no clock edges leaves a stale arm from an earlier frame standing,
	// so the arm must be seen low at least once inside the frame before it may count
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			arm_fresh_reg <= 1'b0;
		end else if (cs_sync_reg && !cs_prev_reg) begin
			arm_fresh_reg <= 1'b0;
		end else if (!cs_sync_reg && !armed_sync_reg) begin
			arm_fresh_reg <= 1'b1;
		end
	end

	// arm settles no later than chip select since it is set before the rise
	assign accept = cs_sync_reg && !cs_prev_reg && armed_sync_reg && arm_fresh_reg &&
		protect.write_enable_latch &&
		!(protect.block_protect_hi && protect.block_protect_lo) &&
		!lock_reg && !wip_reg && init_done_reg;

	// lock flag loads from the nonvolatile cell once after reset, then only ever sets
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			init_done_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else if (!init_done_reg) begin
			init_done_reg <= 1'b1;
			lock_reg <= lock_nv_state;
		end else if (wip_reg && timer_reg == TW'(WRITE_CYCLES - 1)) begin
			lock_reg <= 1'b1;
		end
	end

	// self-timed write cycle, one pulse each for latch clear and cell commit
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			wip_reg <= 1'b0;
			timer_reg <= '0;
			wel_clear_reg <= 1'b0;
			commit_reg <= 1'b0;
		end else begin
			wel_clear_reg <= 1'b0;
			commit_reg <= 1'b0;
			if (accept) begin
				wip_reg <= 1'b1;
				timer_reg <= '0;
			end else if (wip_reg) begin
				if (timer_reg == TW'(WRITE_CYCLES - 1)) begin
					wip_reg <= 1'b0;
					wel_clear_reg <= 1'b1;
					commit_reg <= 1'b1;
				end else begin
					timer_reg <= timer_reg + 1'b1;
				end
			end
		end
	end

	assign write_status = '{write_in_progress: wip_reg, wel_clear: wel_clear_reg,
		sector_locked: lock_reg, lock_nv_commit: commit_reg};

	// system side checks
	chk_lock_needs_wel: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
		$rose(wip_reg) |-> $past(protect.write_enable_latch)) else $error("lock started without latch");
	chk_lock_discard: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
		$rose(wip_reg) |-> !$past(lock_reg) && !($past(protect.block_protect_hi) && $past(protect.block_protect_lo)))
		else $error("lock started while protected or locked");
	chk_write_finish: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
		$fell(wip_reg) |-> lock_reg && wel_clear_reg && commit_reg) else $error("write end without lock");
	chk_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
		(init_done_reg && lock_reg) |=> lock_reg) else $error("lock flag dropped");
	chk_idle_deselect: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
		cs_sync_reg && cs_prev_reg |-> !serial_out_en) else $error("output driven while deselected");
	// link side checks
	// checked on the falling edge, since a good lock frame has no rising edge after the 32nd
	chk_arm_decode: assert property (@(negedge spi_clk) disable iff (!link_rst_n)
		($changed(bit_cnt_reg) && bit_cnt_reg == `CNT_OVER) |->
		armed_reg == (mode_reg == MODE_LOCK && shift_reg[`LOCK_DATA_BIT])) else $error("lock frame arm decode wrong");
	chk_arm_cancel: assert property (@(negedge spi_clk) disable iff (!link_rst_n)
		(bit_cnt_reg == `CNT_OVER && !$changed(bit_cnt_reg)) |-> !armed_reg) else $error("late edge kept lock armed");
	chk_uid_wrap: assert property (@(posedge spi_clk) disable iff (!link_rst_n)
		(mode_reg == MODE_UID && push_valid && push_ready && ptr_now == 4'hf) |=> ptr_reg == 4'h0)
		else $error("identifier pointer did not wrap");
	chk_read_drives: assert property (@(posedge spi_clk) disable iff (!link_rst_n)
		(bit_cnt_reg >= 6'h18 && reading) |-> serial_out_en && head_valid) else $error("read stalled");
	chk_status_byte: assert property (@(posedge spi_clk) disable iff (!link_rst_n)
		(mode_reg == MODE_STATUS && head_valid) |-> head_data[7:2] == 6'h00 && head_data[0] == 1'b0)
		else $error("status byte changed");
	cov_lock_accepted: cover property (@(posedge ref_clk) disable iff (!rst_n_reg) accept);
	cov_uid_wrap: cover property (@(posedge spi_clk) disable iff (!link_rst_n) mode_reg == MODE_UID && ptr_reg == 4'h0
		&& bit_cnt_reg == `CNT_OVER);
	cov_status_read: cover property (@(posedge spi_clk) disable iff (!link_rst_n) mode_reg == MODE_STATUS && head_ready);
	cov_lock_cancel: cover property (@(posedge spi_clk) disable iff (!link_rst_n) armed_reg ##1 !armed_reg);
endmodule

// *** spi_host_model.sv ***
// spi host model that frames lock, lock status and identifier instructions
`timescale 1ns/10ps
module spi_host_model (
	// link lines driven by the host
	output logic spi_clk,
	output logic cs_n,
	output logic serial_in,
	// device answer
	input wire logic serial_out,
	input wire logic serial_out_en
);
	// clock stands low between frames (mode 0), chip select idles high
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end

	// one frame: ntx bits msb first, then nrx bits sampled on rising edges
	task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx, output logic [127:0] rx,
		output logic en_all);
		rx = '0;
		en_all = 1'b1;
		cs_n = 1'b0;
		#40;
		// data set while the clock is low, taken by the device on the rise
		for (int i = ntx - 1; i >= 0; i--) begin
			serial_in = tx[i];
			#62.5 spi_clk = 1'b1;
			#62.5 spi_clk = 1'b0;
		end
		// line is not held during readback: toggle so a stale level is never trusted
		for (int i = 0; i < nrx; i++) begin
			serial_in = ~serial_in;
			#62.5 spi_clk = 1'b1;
			rx = {rx[126:0], serial_out};
			en_all = en_all & serial_out_en;
			#62.5 spi_clk = 1'b0;
		end
		// chip select rises after the last falling edge, before any further rise
		#20 cs_n = 1'b1;
		serial_in = ~serial_in;
		#200;
	endtask
endmodule

// *** tb_top.sv ***
// testbench for the security sector lock and unique identifier read logic
`timescale 1ns/10ps
module tb_top;
	import sector_lock_pkg::*;

	// identifier value is arbitrary
	localparam logic [127:0] UID_TB = 128'h00112233445566778899aabbccddeeff;
	localparam int LIMIT = 60000;
	logic ref_clk;
	logic nrst;
	protect_s protect;
	logic lock_nv_state;
	write_status_s write_status;
	wire logic spi_clk;
	wire logic cs_n;
	wire logic serial_in;
	logic serial_out;
	logic serial_out_en;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	// short write time keeps the run small
	sector_lock_uid #(.WRITE_CYCLES(20), .UID_VALUE(UID_TB)) u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en), .protect(protect),
		.lock_nv_state(lock_nv_state), .write_status(write_status));

	spi_host_model u_host (.spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en));

	// system clock, 4 ns period
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("Error at %0t: run did not finish in time", $time);
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic do_reset(input logic nv);
		@(posedge ref_clk);
		nrst <= 1'b0;
		lock_nv_state <= nv;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask

	// count busy cycles and end-of-write pulses while a frame runs
	task automatic watch(input int n, output int w, output int c, output int m);
		w = 0;
		c = 0;
		m = 0;
		repeat (n) begin
			@(negedge ref_clk);
			if (write_status.write_in_progress === 1'b1) w++;
			if (write_status.wel_clear === 1'b1) c++;
			if (write_status.lock_nv_commit === 1'b1) m++;
		end
	endtask

	function automatic logic [39:0] lk(input logic [15:0] addr, input logic [7:0] data);
		return {8'h00, 8'h82, addr, data};
	endfunction

	// lock attempt; a refused one shows no busy time and no pulses
	task automatic lock_try(input logic [2:0] prot, input logic [39:0] tx, input int ntx, input logic ok,
		input logic locked_after);
		int w;
		int c;
		int m;
		logic [127:0] rx;
		logic en;
		@(posedge ref_clk);
		protect <= prot;
		fork
			u_host.xfer(tx, ntx, 0, rx, en);
			watch(1200, w, c, m);
		join
		check((w == 0) ? 8'h00 : ((w >= 20 && w <= 24) ? 8'h01 : 8'hee), {7'h0, ok}, "busy time");
		check(8'(c), {7'h0, ok}, "latch clear pulses");
		check(8'(m), {7'h0, ok}, "commit pulses");
		check({7'h0, write_status.sector_locked}, {7'h0, locked_after}, "sector locked");
		$display("test lock attempt prot %b bits %0d done", prot, ntx);
	endtask

	task automatic status_read(input logic [7:0] exp);
		logic [127:0] rx;
		logic en;
		u_host.xfer({16'h0000, 8'h83, 16'hfda5}, 24, 24, rx, en);
		for (int j = 0; j < 3; j++)
			check(rx[8 * j +: 8], exp, "status byte");
		check({7'h0, en}, 8'h01, "output enable in read");
		check({6'h0, serial_out_en, serial_out}, 8'h00, "output after deselect");
		$display("test status read done");
	endtask

	task automatic uid_read(input logic [3:0] start, input int n);
		logic [127:0] rx;
		logic en;
		int k;
		u_host.xfer({16'h0000, 8'h83, 16'hc200 | {12'h000, start}}, 24, 8 * n, rx, en);
		for (int j = 0; j < n; j++) begin
			k = (start + j) % 16;
			check(rx[8 * (n - 1 - j) +: 8], UID_TB[127 - 8 * k -: 8], "identifier byte");
		end
		check({7'h0, en}, 8'h01, "output enable in read");
		check({6'h0, serial_out_en, serial_out}, 8'h00, "output after deselect");
		$display("test identifier read from %0d done", start);
	endtask

	initial begin
		nrst = 1'b0;
		protect = 3'b000;
		lock_nv_state = 1'b0;
		do_reset(1'b0);
		check({2'h0, write_status, serial_out_en, serial_out}, 8'h00, "outputs after reset");
		status_read(8'h00);
		uid_read(4'he, 4);
		uid_read(4'h5, 16);
		lock_try(3'b000, lk(16'h0400, 8'h02), 32, 1'b0, 1'b0);
		lock_try(3'b001, 40'h00_0000_0000, 0, 1'b0, 1'b0);
		lock_try(3'b111, lk(16'h0400, 8'h02), 32, 1'b0, 1'b0);
		lock_try(3'b001, lk(16'h0400, 8'hfd), 32, 1'b0, 1'b0);
		lock_try(3'b001, lk(16'h0400, 8'h02) >> 1, 31, 1'b0, 1'b0);
		lock_try(3'b001, lk(16'h0400, 8'h02) << 1, 33, 1'b0, 1'b0);
		lock_try(3'b001, lk(16'hf9ff, 8'h02), 32, 1'b0, 1'b0);
		lock_try(3'b101, lk(16'hfdff, 8'hfe), 32, 1'b1, 1'b1);
		status_read(8'h02);
		lock_try(3'b001, lk(16'h0400, 8'h02), 32, 1'b0, 1'b1);
		do_reset(1'b1);
		check({7'h0, write_status.sector_locked}, 8'h01, "lock after power cycle");
		status_read(8'h02);
		finish_test();
	end
endmodule
